// file: logic/tdm_device_end.sv
`timescale 1ns/1ps
`default_nettype none

module tdm_device_end
  import tdm_timing_pkg::*;
(
  tdm_link_if.device         lnk,
  input  wire  logic         MCLK,
  input  wire  logic         RST_B,
  input  wire  logic         LINE_ACTIVATED,
  input  wire  logic signed [3:0] RX_TRIM,
  input  wire  logic         TEST_IN,
  output var   logic         TEST_OUT,
  output var   logic         NETWORK_MODE,
  output var   logic         FRAME_START,
  output var   logic         SUPERFRAME_START
);

  // ---------------- reference clock domain ----------------
  logic [IN_W-1:0]  in_meta_reg;
  logic [IN_W-1:0]  in_sync_reg;
  logic [NCO_W-1:0] acc_reg;
  logic             clk_reg;
  logic             clk_oe_reg;
  logic             test_out_reg;
  logic             net_reg;
  logic [2:0]       fr_sync_reg;
  logic [2:0]       sf_sync_reg;
  logic             fr_pulse_reg;
  logic             sf_pulse_reg;
  logic [HLD_W-1:0] hld_cnt_reg;
  logic             lrst_src_reg;
  logic             fr_tgl_reg;
  logic             sf_tgl_reg;

  logic [NCO_W-1:0] step_trim;
  logic [NCO_W:0]   acc_sum;
  logic [IN_W-1:0]  in_pins;
  logic             drive_next;
  logic             hld_done;
  logic [HLD_W-1:0] hld_next;

  // receiver trim nudges the rate so the clock tracks the line
  assign step_trim  = NCO_STEP + NCO_W'(RX_TRIM);
  assign acc_sum    = nco_add(acc_reg, step_trim);
  assign in_pins    = {TEST_IN, lnk.superframe_pulse_n, lnk.frame_pulse_n,
                       lnk.io_test_enable, lnk.line_end_select};
  assign drive_next = in_sync_reg[IN_SEL] | in_sync_reg[IN_TEN];
  // stretch of the link reset, counted in reference cycles
  assign hld_done   = (hld_cnt_reg == HLD_LAST);
  assign hld_next   = hld_done ? hld_cnt_reg : hld_cnt_reg + 1'b1;

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      in_meta_reg  <= '0;
      in_sync_reg  <= '0;
      acc_reg      <= NCO_RESET;
      clk_reg      <= 1'b1;
      clk_oe_reg   <= 1'b0;
      test_out_reg <= 1'b0;
      net_reg      <= 1'b0;
    end else begin
      in_meta_reg  <= in_pins;
      in_sync_reg  <= in_meta_reg;
      acc_reg      <= acc_sum[NCO_W-1:0];
      clk_reg      <= clk_reg ^ acc_sum[NCO_W];
      clk_oe_reg   <= drive_next;
      test_out_reg <= ^in_sync_reg;
      net_reg      <= in_sync_reg[IN_SEL];
    end
  end

  // the link side only sees reset on bit clock edges, and nobody drives
  // that clock during reset, so its reset is held for a while after release
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      hld_cnt_reg  <= HLD_ZERO;
      lrst_src_reg <= 1'b0;
    end else begin
      hld_cnt_reg  <= hld_next;
      lrst_src_reg <= hld_done;
    end
  end

  // toggles from the link side, edge found after two flops; held clear
  // until the link side is out of reset so a stale toggle cannot leak
  always_ff @(posedge MCLK) begin
    if (!RST_B || !lrst_src_reg) begin
      fr_sync_reg  <= '0;
      sf_sync_reg  <= '0;
      fr_pulse_reg <= 1'b0;
      sf_pulse_reg <= 1'b0;
    end else begin
      fr_sync_reg  <= {fr_sync_reg[1:0], fr_tgl_reg};
      sf_sync_reg  <= {sf_sync_reg[1:0], sf_tgl_reg};
      fr_pulse_reg <= fr_sync_reg[2] ^ fr_sync_reg[1];
      sf_pulse_reg <= sf_sync_reg[2] ^ sf_sync_reg[1];
    end
  end

  assign lnk.dev_clk_o  = clk_reg;
  assign lnk.dev_clk_oe = clk_oe_reg;
  assign TEST_OUT         = test_out_reg;
  assign NETWORK_MODE     = net_reg;
  assign FRAME_START      = fr_pulse_reg;
  assign SUPERFRAME_START = sf_pulse_reg;

  // ---------------- link clock domain ----------------
  // sampled on the falling edge; the link clock may stop between
  // frames, so everything here just waits for the next edge
  logic               lrst_meta_reg;
  logic               lrst_reg;
  logic [LK_W-1:0]    lk_meta_reg;
  logic [LK_W-1:0]    lk_sync_reg;
  logic [BIT_W-1:0]   bit_cnt_reg;
  logic [FRAME_W-1:0] frame_cnt_reg;
  logic               fp_o_reg;
  logic               sf_o_reg;
  logic               pin_oe_reg;

  logic               lk_net;
  logic               lk_test;
  logic               fp_seen;
  logic               sf_seen;
  logic               bit_wrap;
  logic [BIT_W-1:0]   bit_free;
  logic [FRAME_W-1:0] frame_free;
  logic [BIT_W-1:0]   bit_next;
  logic [FRAME_W-1:0] frame_next;
  logic               at_frame;
  logic               at_sf;
  logic               in_pulse;

  assign lk_net     = lk_sync_reg[LK_SEL];
  assign lk_test    = lk_sync_reg[LK_TEN];
  assign fp_seen    = !lnk.frame_pulse_n;
  assign sf_seen    = fp_seen && !lnk.superframe_pulse_n;
  assign bit_wrap   = (bit_cnt_reg == BIT_LAST);
  assign bit_free   = bit_wrap ? BIT_ZERO : bit_cnt_reg + 1'b1;
  assign frame_free = !bit_wrap ? frame_cnt_reg :
                      (frame_cnt_reg == FRAME_LAST) ? FRAME_ZERO :
                      frame_cnt_reg + 1'b1;
  // exchange side: the system's pulses realign the counters
  assign bit_next   = (!lk_net && fp_seen) ? BIT_ZERO : bit_free;
  assign frame_next = (!lk_net && sf_seen) ? FRAME_ZERO
                                           : frame_free;
  assign at_frame   = (bit_next == BIT_ZERO);
  assign at_sf      = at_frame && (frame_next == FRAME_ZERO);
  assign in_pulse   = (bit_next < PULSE_BITS);

  always_ff @(negedge lnk.bit_clock_4m) begin
    lrst_meta_reg <= lrst_src_reg;
    lrst_reg      <= lrst_meta_reg;
  end

  always_ff @(negedge lnk.bit_clock_4m) begin
    if (!lrst_reg) begin
      lk_meta_reg   <= '0;
      lk_sync_reg   <= '0;
      bit_cnt_reg   <= BIT_ZERO;
      frame_cnt_reg <= FRAME_ZERO;
      fp_o_reg      <= 1'b1;
      sf_o_reg      <= 1'b1;
      pin_oe_reg    <= 1'b0;
      fr_tgl_reg    <= 1'b0;
      sf_tgl_reg    <= 1'b0;
    end else begin
      lk_meta_reg   <= {TEST_IN, lnk.io_test_enable, lnk.line_end_select,
                        LINE_ACTIVATED};
      lk_sync_reg   <= lk_meta_reg;
      bit_cnt_reg   <= bit_next;
      frame_cnt_reg <= frame_next;
      pin_oe_reg    <= lk_net | lk_test;
      fr_tgl_reg    <= fr_tgl_reg ^ at_frame;
      sf_tgl_reg    <= sf_tgl_reg ^ at_sf;
      if (lk_test) begin
        fp_o_reg <= lk_sync_reg[LK_TIN];
        sf_o_reg <= lk_sync_reg[LK_TIN];
      end else begin
        fp_o_reg <= !(at_frame && in_pulse);
        sf_o_reg <= !(at_sf && in_pulse
                      && lk_sync_reg[LK_ACT]);
      end
    end
  end

  assign lnk.dev_fp_o  = fp_o_reg;
  assign lnk.dev_sf_o  = sf_o_reg;
  assign lnk.dev_fp_oe = pin_oe_reg;
  assign lnk.dev_sf_oe = pin_oe_reg;

endmodule : tdm_device_end

`default_nettype wire

// file: logic/tdm_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface tdm_link_if;

  // resolved pin levels; idle high when nobody drives
  logic bit_clock_4m;
  logic frame_pulse_n;
  logic superframe_pulse_n;

  // straps from the system to the device
  logic line_end_select;
  logic io_test_enable;

  logic dev_clk_o;
  logic dev_clk_oe;
  logic dev_fp_o;
  logic dev_fp_oe;
  logic dev_sf_o;
  logic dev_sf_oe;
  logic sys_clk_o;
  logic sys_clk_oe;
  logic sys_fp_o;
  logic sys_fp_oe;
  logic sys_sf_o;
  logic sys_sf_oe;

  assign bit_clock_4m = dev_clk_oe ? dev_clk_o :
                        (sys_clk_oe ? sys_clk_o : 1'b1);
  assign frame_pulse_n = dev_fp_oe ? dev_fp_o :
                         (sys_fp_oe ? sys_fp_o : 1'b1);
  assign superframe_pulse_n = dev_sf_oe ? dev_sf_o :
                              (sys_sf_oe ? sys_sf_o : 1'b1);

  modport device (
    input  bit_clock_4m, frame_pulse_n, superframe_pulse_n,
    input  line_end_select, io_test_enable,
    output dev_clk_o, dev_clk_oe, dev_fp_o, dev_fp_oe, dev_sf_o, dev_sf_oe
  );

  modport system (
    input  bit_clock_4m, frame_pulse_n, superframe_pulse_n,
    output line_end_select, io_test_enable,
    output sys_clk_o, sys_clk_oe, sys_fp_o, sys_fp_oe, sys_sf_o, sys_sf_oe
  );

endinterface : tdm_link_if

`default_nettype wire

// file: logic/tdm_system_end.sv
`timescale 1ns/1ps
`default_nettype none

module tdm_system_end
  import tdm_timing_pkg::*;
(
  tdm_link_if.system   lnk,
  input  wire  logic   MCLK,
  input  wire  logic   RST_B,
  input  wire  logic   MODE_NETWORK,
  input  wire  logic   TEST_ENABLE,
  output var   logic   FRAME_SEEN,
  output var   logic   SUPERFRAME_SEEN
);

  logic               sel_reg;
  logic               ten_reg;
  logic [NCO_W-1:0]   acc_reg;
  logic               clk_reg;
  logic               oe_reg;
  logic [BIT_W-1:0]   bit_cnt_reg;
  logic [FRAME_W-1:0] frame_cnt_reg;
  logic               fp_reg;
  logic               sf_reg;
  logic [RX_W-1:0]    rx_meta_reg;
  logic [RX_W-1:0]    rx_sync_reg;
  logic               rx_clk_d_reg;
  logic               fr_seen_reg;
  logic               sf_seen_reg;

  logic [NCO_W:0]     acc_sum;
  logic               rise;
  logic               bit_wrap;
  logic [BIT_W-1:0]   bit_next;
  logic [FRAME_W-1:0] frame_next;
  logic               rx_fall;

  assign acc_sum    = nco_add(acc_reg, NCO_STEP);
  // counters and pulses move on the rising edge so the device sees
  // them settled at its falling-edge sample
  assign rise       = acc_sum[NCO_W] && !clk_reg;
  assign bit_wrap   = (bit_cnt_reg == BIT_LAST);
  assign bit_next   = bit_wrap ? BIT_ZERO : bit_cnt_reg + 1'b1;
  assign frame_next = !bit_wrap ? frame_cnt_reg :
                      (frame_cnt_reg == FRAME_LAST) ? FRAME_ZERO :
                      frame_cnt_reg + 1'b1;
  assign rx_fall    = rx_clk_d_reg && !rx_sync_reg[RX_CLK];

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      sel_reg       <= 1'b0;
      ten_reg       <= 1'b0;
      acc_reg       <= NCO_RESET;
      clk_reg       <= 1'b1;
      oe_reg        <= 1'b0;
      bit_cnt_reg   <= BIT_ZERO; // first frame a frame after release
      frame_cnt_reg <= FRAME_LAST;
      fp_reg        <= 1'b1;
      sf_reg        <= 1'b1;
      rx_meta_reg   <= '1;
      rx_sync_reg   <= '1;
      rx_clk_d_reg  <= 1'b1;
      fr_seen_reg   <= 1'b0;
      sf_seen_reg   <= 1'b0;
    end else begin
      sel_reg      <= MODE_NETWORK;
      ten_reg      <= TEST_ENABLE;
      acc_reg      <= acc_sum[NCO_W-1:0];
      clk_reg      <= clk_reg ^ acc_sum[NCO_W];
      oe_reg       <= !sel_reg && !ten_reg;
      if (rise) begin
        bit_cnt_reg   <= bit_next;
        frame_cnt_reg <= frame_next;
        fp_reg <= !((bit_next == BIT_ZERO)
                    && (bit_next < PULSE_BITS));
        sf_reg <= !((bit_next == BIT_ZERO)
                    && (frame_next == FRAME_ZERO));
      end
      rx_meta_reg  <= {lnk.superframe_pulse_n, lnk.frame_pulse_n,
                       lnk.bit_clock_4m};
      rx_sync_reg  <= rx_meta_reg;
      rx_clk_d_reg <= rx_sync_reg[RX_CLK];
      fr_seen_reg  <= rx_fall && !rx_sync_reg[RX_FP];
      sf_seen_reg  <= rx_fall && !rx_sync_reg[RX_FP]
                      && !rx_sync_reg[RX_SF];
    end
  end

  assign lnk.line_end_select = sel_reg;
  assign lnk.io_test_enable  = ten_reg;
  assign lnk.sys_clk_o       = clk_reg;
  assign lnk.sys_clk_oe      = oe_reg;
  assign lnk.sys_fp_o        = fp_reg;
  assign lnk.sys_fp_oe       = oe_reg;
  assign lnk.sys_sf_o        = sf_reg;
  assign lnk.sys_sf_oe       = oe_reg;
  assign FRAME_SEEN          = fr_seen_reg;
  assign SUPERFRAME_SEEN     = sf_seen_reg;

endmodule : tdm_system_end

`default_nettype wire

// file: logic/tdm_timing_pkg.sv
package tdm_timing_pkg;

  // time figures in their own units
  localparam int MCLK_KHZ      = 20000;
  localparam int CLK4_KHZ      = 4096;
  localparam int FRAME_KHZ     = 8;
  localparam int SUPERFRAME_MS = 12;
  localparam int SF_PULSE_NS   = 244;

  // derived counts: bit clock periods per frame and pulse, frames per superframe
  localparam int BITS_PER_FRAME = CLK4_KHZ / FRAME_KHZ;
  localparam int FRAMES_PER_SF  = SUPERFRAME_MS * FRAME_KHZ;
  localparam int PULSE_RAW      = (SF_PULSE_NS * CLK4_KHZ) / 1000000;
  localparam int PULSE_CYC      = (PULSE_RAW < 1) ? 1 : PULSE_RAW;

  localparam int BIT_W   = $clog2(BITS_PER_FRAME);
  localparam int FRAME_W = $clog2(FRAMES_PER_SF);

  localparam logic [BIT_W-1:0]   BIT_LAST   = BIT_W'(BITS_PER_FRAME - 1);
  localparam logic [BIT_W-1:0]   BIT_ZERO   = 9'h000;
  localparam logic [BIT_W-1:0]   PULSE_BITS = BIT_W'(PULSE_CYC);
  localparam logic [FRAME_W-1:0] FRAME_LAST = FRAME_W'(FRAMES_PER_SF - 1);
  localparam logic [FRAME_W-1:0] FRAME_ZERO = 7'h00;

  // reference cycles the link side stays in reset after release; long
  // enough for several bit clock periods once that clock starts
  localparam int HLD_CYC = 32;
  localparam int HLD_W   = $clog2(HLD_CYC + 1);
  localparam logic [HLD_W-1:0] HLD_LAST = HLD_W'(HLD_CYC);
  localparam logic [HLD_W-1:0] HLD_ZERO = 6'h00;

  // phase accumulator toggling the bit clock at twice its rate
  localparam int NCO_W = 16;
  localparam logic [NCO_W-1:0] NCO_STEP =
    NCO_W'((2 * CLK4_KHZ * (1 << NCO_W)) / MCLK_KHZ);
  localparam logic [NCO_W-1:0] NCO_RESET = 16'h0000;

  // positions in the device's sampled pin vector
  localparam int IN_SEL  = 0;
  localparam int IN_TEN  = 1;
  localparam int IN_FP   = 2;
  localparam int IN_SF   = 3;
  localparam int IN_TIN  = 4;
  localparam int IN_W    = 5;

  // positions in the device's link-side level vector
  localparam int LK_ACT  = 0;
  localparam int LK_SEL  = 1;
  localparam int LK_TEN  = 2;
  localparam int LK_TIN  = 3;
  localparam int LK_W    = 4;

  // positions in the system's received pin vector
  localparam int RX_CLK  = 0;
  localparam int RX_FP   = 1;
  localparam int RX_SF   = 2;
  localparam int RX_W    = 3;

  function automatic logic [NCO_W:0] nco_add(
    input logic [NCO_W-1:0] acc,
    input logic [NCO_W-1:0] step
  );
    return {1'b0, acc} + {1'b0, step};
  endfunction : nco_add

endpackage : tdm_timing_pkg

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import tdm_timing_pkg::*;

  // one frame in reference cycles, bit clock rises in a 2000 cycle window
  localparam int GAP  = BITS_PER_FRAME * MCLK_KHZ / CLK4_KHZ;
  localparam int CLKS = 2000 * CLK4_KHZ / MCLK_KHZ;

  logic              MCLK        = 1'b0;
  logic              RST_B       = 1'b0;
  logic              activated   = 1'b0;
  logic              test_in     = 1'b0;
  logic              mode_net    = 1'b0;
  logic              test_en     = 1'b0;
  logic signed [3:0] trim        = 4'sh0;
  logic              test_out;
  logic              net_mode;
  logic              fr_start;
  logic              sf_start;
  logic              fr_seen;
  logic              sf_seen;
  int                n_mismatch  = 0;
  int                comparisons = 0;

  tdm_link_if lnk ();

  always #25 MCLK = ~MCLK;

  tdm_device_end tdm_device_end_inst (.lnk(lnk), .MCLK(MCLK),
    .RST_B(RST_B), .LINE_ACTIVATED(activated), .RX_TRIM(trim),
    .TEST_IN(test_in), .TEST_OUT(test_out), .NETWORK_MODE(net_mode),
    .FRAME_START(fr_start), .SUPERFRAME_START(sf_start));

  tdm_system_end tdm_system_end_inst (.lnk(lnk), .MCLK(MCLK),
    .RST_B(RST_B), .MODE_NETWORK(mode_net), .TEST_ENABLE(test_en),
    .FRAME_SEEN(fr_seen), .SUPERFRAME_SEEN(sf_seen));

  tdm_link_monitor tdm_link_monitor_inst (.MCLK(MCLK), .RST_B(RST_B),
    .bit_clock_4m(lnk.bit_clock_4m), .frame_pulse_n(lnk.frame_pulse_n),
    .superframe_pulse_n(lnk.superframe_pulse_n),
    .line_end_select(lnk.line_end_select),
    .io_test_enable(lnk.io_test_enable), .dev_clk_oe(lnk.dev_clk_oe),
    .dev_fp_oe(lnk.dev_fp_oe), .dev_sf_oe(lnk.dev_sf_oe),
    .sys_clk_oe(lnk.sys_clk_oe), .sys_fp_oe(lnk.sys_fp_oe));

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check

  task automatic results();
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask : tick

  // gap between device frame starts, with system sightings inside it
  task automatic frame(output int gap, output int seen, output int sfs);
    int i;
    gap = 0;
    seen = 0;
    sfs = 0;
    for (i = 0; i < 3000 && fr_start !== 1'b1; i++)
      tick(1);
    for (i = 0; i < 3000 && gap == 0; i++) begin
      tick(1);
      seen += int'(fr_seen === 1'b1);
      sfs += int'(sf_start === 1'b1 || sf_seen === 1'b1);
      if (fr_start === 1'b1)
        gap = i + 1;
    end
  endtask : frame

  task automatic rate_ok(output logic ok);
    int   n;
    logic last;
    n = 0;
    last = lnk.bit_clock_4m;
    repeat (2000) begin
      tick(1);
      n += int'(lnk.bit_clock_4m === 1'b1 && last === 1'b0);
      last = lnk.bit_clock_4m;
    end
    ok = (n >= CLKS - 2 && n <= CLKS + 2);
  endtask : rate_ok

  task automatic frames_ok(input int want_seen);
    int g;
    int s;
    int f;
    frame(g, s, f);
    check("frame_gap", 32'(g >= GAP - 4 && g <= GAP + 4), 1);
    check("frame_seen", 32'(s), 32'(want_seen));
    check("sf_mid", 32'(f), 0);
  endtask : frames_ok

  initial begin : watchdog
    repeat (100000) @(posedge MCLK);
    n_mismatch++;
    results();
  end

  initial begin : main
    int   i;
    logic v;
    logic ok;
    tick(7);
    check("clk_oe_rst", 32'(lnk.dev_clk_oe), 0);
    check("mode_rst", 32'(net_mode), 0);
    tick(1);
    RST_B = 1'b1;
    for (i = 0; i < 2 * GAP + 500 && sf_start !== 1'b1; i++)
      tick(1);
    check("sf_start", 32'(sf_start), 1);
    check("sys_clk_oe", 32'(lnk.sys_clk_oe), 1);
    check("dev_fp_oe", 32'(lnk.dev_fp_oe), 0);
    check("mode_exch", 32'(net_mode), 0);
    rate_ok(ok);
    check("rate_exch", 32'(ok), 1);
    frames_ok(1);
    // pins follow the test source while the structure test runs
    test_en = 1'b1;
    for (int k = 0; k < 3; k++) begin
      v = (k == 1);
      test_in = v;
      for (i = 0; i < 200 && !(lnk.frame_pulse_n === v &&
           lnk.superframe_pulse_n === v && test_out === !v); i++)
        tick(1);
      check("test_fp", 32'(lnk.frame_pulse_n), 32'(v));
      check("test_sf", 32'(lnk.superframe_pulse_n), 32'(v));
      check("test_out", 32'(test_out), 32'(!v));
    end
    test_en = 1'b0;
    test_in = 1'b0;
    // the exchange counters realign to the system's next frame pulse
    tick(GAP + 100);
    frames_ok(1);
    mode_net = 1'b1;
    for (i = 0; i < 20 && net_mode !== 1'b1; i++)
      tick(1);
    check("mode_net", 32'(net_mode), 1);
    tick(60);
    check("net_sys_oe", 32'(lnk.sys_clk_oe), 0);
    check("net_fp_oe", 32'(lnk.dev_fp_oe), 1);
    rate_ok(ok);
    check("rate_net", 32'(ok), 1);
    frames_ok(1);
    frames_ok(1);
    mode_net = 1'b0;
    tick(60);
    check("back_fp_oe", 32'(lnk.dev_fp_oe), 0);
    check("back_mode", 32'(net_mode), 0);
    tick(GAP);
    frames_ok(1);
    // second reset straight into network mode with the line active
    mode_net = 1'b1;
    activated = 1'b1;
    RST_B = 1'b0;
    tick(8);
    check("mode_rst2", 32'(net_mode), 0);
    RST_B = 1'b1;
    frames_ok(1);
    results();
  end

endmodule : tb_top

`default_nettype wire

// file: verif/tdm_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module tdm_link_monitor (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic bit_clock_4m,
  input wire logic frame_pulse_n,
  input wire logic superframe_pulse_n,
  input wire logic line_end_select,
  input wire logic io_test_enable,
  input wire logic dev_clk_oe,
  input wire logic dev_fp_oe,
  input wire logic dev_sf_oe,
  input wire logic sys_clk_oe,
  input wire logic sys_fp_oe
);
  logic [5:0] calm_reg;
  logic [9:0] bits_reg;
  logic       had_fp_reg;
  wire logic  net_run;
  wire logic  calm;

  assign net_run = line_end_select && !io_test_enable;
  assign calm    = (calm_reg == 6'h3F);

  // both ends may drive briefly while straps settle, so wait before judging
  always_ff @(posedge MCLK) begin
    if (!RST_B || $changed(line_end_select) || $changed(io_test_enable))
      calm_reg <= 6'h00;
    else if (!calm)
      calm_reg <= calm_reg + 6'h01;
  end

  always_ff @(negedge bit_clock_4m) begin
    if (!RST_B || !net_run || !frame_pulse_n)
      bits_reg <= 10'h000;
    else
      bits_reg <= bits_reg + 10'h001;
    if (!RST_B || !net_run)
      had_fp_reg <= 1'b0;
    else if (!frame_pulse_n)
      had_fp_reg <= 1'b1;
  end

  sequence sf_then_idle;
    !frame_pulse_n ##1 superframe_pulse_n;
  endsequence

  AST_NET_TAKES: assert property (@(posedge MCLK)
    disable iff (!RST_B)
    $rose(line_end_select) |-> ##[1:8] (dev_clk_oe && !sys_clk_oe))
    else $error("device did not take the bit clock");

  AST_EXCH_RELEASES: assert property (@(posedge MCLK)
    disable iff (!RST_B)
    ($fell(line_end_select) && !io_test_enable)
      |-> ##[1:8] (!dev_clk_oe && sys_clk_oe))
    else $error("bit clock not handed back to the system");

  AST_NO_CONTEND: assert property (@(posedge MCLK)
    disable iff (!RST_B)
    (calm && !io_test_enable)
      |-> !(dev_clk_oe && sys_clk_oe) && !(dev_fp_oe && sys_fp_oe))
    else $error("both ends drive a timing pin");

  AST_RESET_QUIET: assert property (@(posedge MCLK)
    disable iff (!RST_B)
    $rose(RST_B) |-> (!dev_clk_oe && !sys_clk_oe && !line_end_select))
    else $error("pins driven during reset");

  AST_FP_ONE_BIT: assert property (@(negedge bit_clock_4m)
    disable iff (!RST_B)
    (net_run && dev_fp_oe && $fell(frame_pulse_n)) |=> frame_pulse_n)
    else $error("frame pulse not one bit clock wide");

  AST_FRAME_PERIOD: assert property (@(negedge bit_clock_4m)
    disable iff (!RST_B)
    (net_run && had_fp_reg && !frame_pulse_n) |-> (bits_reg == 10'h1FF))
    else $error("frame pulses not 512 bit clocks apart");

  AST_SF_ON_FRAME: assert property (@(negedge bit_clock_4m)
    disable iff (!RST_B)
    (net_run && dev_sf_oe && !superframe_pulse_n) |-> sf_then_idle)
    else $error("superframe pulse off frame or too wide");

  AST_TEST_TAKES: assert property (@(posedge MCLK)
    disable iff (!RST_B)
    $rose(io_test_enable) |-> ##[1:60] (dev_clk_oe && dev_fp_oe && dev_sf_oe))
    else $error("test mode did not drive all pins");

  AST_TEST_ENDS: assert property (@(posedge MCLK)
    disable iff (!RST_B)
    ($fell(io_test_enable) && !line_end_select) |-> ##[1:60] !dev_fp_oe)
    else $error("frame pin still driven after test");

endmodule : tdm_link_monitor

`default_nettype wire
